// *** src/reset_ctrl_params.svh ***
// Constants for the reset and stop recovery controller.
`ifndef RESET_CTRL_PARAMS_SVH
`define RESET_CTRL_PARAMS_SVH

`define RC_CLK_MHZ            100
`define RC_OSC_START_NS       4000
`define RC_HOLD_CYCLES        66
`define RC_HOLD_XTAL_CYCLES   5000
`define RC_MIN_PULSE_CYCLES   4
`define RC_VECTOR_ADDR_LO     16'h0002
`define RC_VECTOR_ADDR_HI     16'h0003

`define RC_ADR_W              8
`define RC_ADR_DEBUG_CTL      8'h00
`define RC_ADR_OPTION         8'h04
`define RC_ADR_WATCHDOG_CTL   8'h08
`define RC_ADR_RESET_STATUS   8'h0C
`define RC_ADR_OSCILLATOR_CONTROL_REG        8'h10
`define RC_ADR_RECOVERY_EN    8'h14
`define RC_ADR_PORT_IN        8'h18

`define RC_OPT_WATCHDOG_RESET 0
`define RC_OPT_XTAL_ENABLE    1
`define RC_OPT_PIN_ENABLE     2
`define RC_OPTION_RESET       3'h4

`define RC_WCTL_TIMEOUT       0
`define RC_WCTL_STOP          1

`define RC_STAT_POWER_ON      0
`define RC_STAT_BROWNOUT      1
`define RC_STAT_WATCHDOG      2
`define RC_STAT_PIN           3
`define RC_STAT_DEBUGGER      4
`define RC_STAT_STOP          5
`define RC_STAT_POWER_ON_VAL  6'h01

`define RC_CLKSEL_INTERNAL    2'h0

`endif

// *** src/reset_ctrl_pkg.sv ***
// Types shared by the reset and stop recovery controller.
package reset_ctrl_pkg;

  typedef enum {
    st_osc_start,
    st_hold,
    st_pin_wait,
    st_run,
    st_stop
  } seq_state_t;

endpackage

// *** src/sync_if.sv ***
// Raw and synchronised pin levels between the controller and its synchroniser.
`timescale 1ns/1ps
interface sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// *** src/pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  sync_if.sync      pins
);

  logic [W-1:0] first_reg;
  logic [W-1:0] second_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_reg  <= INIT;
      second_reg <= INIT;
    end else begin
      first_reg  <= pins.raw;
      second_reg <= first_reg;
    end
  end

  assign pins.synced = second_reg;

endmodule // pin_sync

// *** src/reset_and_stop_recovery_ctrl.sv ***
// Reset and stop-mode recovery controller with a Wishbone register slave.
//
// How it works
// - Reset from power-on, brownout, watchdog, pin, debugger.
// - Hold core in reset 66 oscillator cycles.
// - Crystal option lengthens hold to 5000 cycles.
// - Wait 4 us oscillator start before counting.
// - Power and brownout holds timed from supply recovery.
// - Held reset pin extends reset until released.
// - Reset forces every GPIO to input, no pull-up.
// - Core idle in reset; oscillators keep running.
// - System reset reloads control registers with defaults, except the option register.
// - Core fetches vector from bytes 0002H and 0003H.
// - System clock returns to internal oscillator after reset.
// - Recovery resets core only, plus oscillator control; watchdog control flags are kept.
// - Every recovery sets the watchdog stop flag.
// - Watchdog time-out in stop sets both flags.
// - Watchdog interrupt serviced after recovery when enabled.
// - Enabled pin edge while stopped starts recovery.
// - Reset pin or debug low in stop: full reset.
// - Short recovery pulse ignored, sets reset-status stop flag.
// - Port input data captured only while running.
// - Crystal enable overrides the two crystal pins.
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module reset_and_stop_recovery_ctrl #(
  parameter int GPIO_W           = 8,
  parameter int CNT_W            = 13,
  parameter int HOLD_XTAL_CYCLES = `RC_HOLD_XTAL_CYCLES,
  parameter int MIN_PULSE_CYCLES = `RC_MIN_PULSE_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [`RC_ADR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_we_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  supply_brownout_i,
  input  wire logic                  reset_pin_n_i,
  input  wire logic                  debug_pin_i,
  input  wire logic [GPIO_W-1:0]     gpio_i,
  input  wire logic                  watchdog_timeout_i,
  input  wire logic                  stop_enter_i,
  input  wire logic                  irq_enable_i,
  output logic                       core_reset_o,
  output logic                       periph_reset_o,
  output logic                       gpio_force_input_o,
  output logic                       vector_fetch_o,
  output logic      [15:0]           vector_addr_lo_o,
  output logic      [15:0]           vector_addr_hi_o,
  output logic                       watchdog_irq_o,
  output logic                       xtal_osc_run_o,
  output logic                       watchdog_osc_run_o,
  output logic                       xtal_pin_override_o,
  output logic      [1:0]            sys_clk_sel_o,
  output logic      [GPIO_W-1:0]     port_input_data_o,
  output logic                       port_capture_en_o,
  output logic                       stopped_o
);

  localparam int OSC_START_CYCLES_RAW =
    (`RC_OSC_START_NS * `RC_CLK_MHZ + 999) / 1000;
  localparam int OSC_START_CYCLES =
    (OSC_START_CYCLES_RAW < 1) ? 1 : OSC_START_CYCLES_RAW;
  localparam int HOLD_CYCLES = `RC_HOLD_CYCLES;
  localparam int SYNC_W      = GPIO_W + 3;

  if (GPIO_W < 1 || GPIO_W > 8) begin : g_check_gpio
    $error("GPIO_W must lie between 1 and 8");
  end
  if (HOLD_XTAL_CYCLES < HOLD_CYCLES ||
      HOLD_XTAL_CYCLES >= (1 << CNT_W) ||
      OSC_START_CYCLES >= (1 << CNT_W)) begin : g_check_cnt
    $error("CNT_W too small for the hold counts");
  end
  if (MIN_PULSE_CYCLES < 1 || MIN_PULSE_CYCLES > 255) begin : g_check_pulse
    $error("MIN_PULSE_CYCLES must lie between 1 and 255");
  end

  // Pin synchronisation.
  sync_if #(.W(SYNC_W)) pins ();

  assign pins.raw = {supply_brownout_i, reset_pin_n_i, debug_pin_i, gpio_i};

  pin_sync #(
    .W    (SYNC_W),
    .INIT ({3'b011, {GPIO_W{1'b0}}})
  ) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pins  (pins)
  );

  logic              brownout_s;
  logic              reset_pin_n_s;
  logic              debug_pin_s;
  logic [GPIO_W-1:0] gpio_s;

  assign brownout_s    = pins.synced[GPIO_W+2];
  assign reset_pin_n_s = pins.synced[GPIO_W+1];
  assign debug_pin_s   = pins.synced[GPIO_W];
  assign gpio_s        = pins.synced[GPIO_W-1:0];

  // Registers.
  reset_ctrl_pkg::seq_state_t state_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              recovery_reg;
  logic              watchdog_wake_reg;
  logic [7:0]        pulse_cnt_reg;
  logic [GPIO_W-1:0] level_ref_reg;
  logic              debugger_control_reg;
  logic [2:0]        option_reg;
  logic [1:0]        watchdog_control_reg;
  logic [5:0]        reset_status_reg;
  logic [1:0]        oscillator_control_reg;
  logic [GPIO_W-1:0] recovery_enable_reg;
  logic [GPIO_W-1:0] port_input_data_reg;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic              core_reset_reg;
  logic              periph_reset_reg;
  logic              vector_fetch_reg;
  logic              watchdog_irq_reg;
  logic              port_capture_en_reg;
  logic              stopped_reg;
  logic              osc_run_reg;

  function automatic logic in_reset(input reset_ctrl_pkg::seq_state_t s);
    in_reset = (s == reset_ctrl_pkg::st_osc_start) ||
               (s == reset_ctrl_pkg::st_hold) ||
               (s == reset_ctrl_pkg::st_pin_wait);
  endfunction

  function automatic logic hit(input logic [`RC_ADR_W-1:0] adr,
                               input logic [`RC_ADR_W-1:0] off);
    hit = ({adr[`RC_ADR_W-1:2], 2'b00} == off);
  endfunction

  // Request decode and wake conditions.
  logic              running;
  logic              stopped;
  logic              pin_asserted;
  logic              watchdog_req;
  logic              pin_req;
  logic              debug_low_req;
  logic              sys_req;
  logic [GPIO_W-1:0] changed;
  logic              wake_watchdog;
  logic              wake_pin;
  logic              wake;
  logic              short_pulse;
  logic [CNT_W-1:0]  hold_last;
  logic              wr;

  assign running       = (state_reg == reset_ctrl_pkg::st_run);
  assign stopped       = (state_reg == reset_ctrl_pkg::st_stop);
  assign pin_asserted  = ~reset_pin_n_s & option_reg[`RC_OPT_PIN_ENABLE];
  assign watchdog_req  = running & watchdog_timeout_i &
                         option_reg[`RC_OPT_WATCHDOG_RESET];
  assign pin_req       = pin_asserted & (running | stopped);
  assign debug_low_req = stopped & ~debug_pin_s;
  assign sys_req       = brownout_s | debugger_control_reg | watchdog_req |
                         pin_req | debug_low_req;
  assign changed       = (gpio_s ^ level_ref_reg) & recovery_enable_reg;
  assign wake_watchdog = stopped & watchdog_timeout_i;
  assign wake_pin      = stopped & (|changed) &
    (pulse_cnt_reg == 8'(MIN_PULSE_CYCLES - 1));
  assign wake          = wake_watchdog | wake_pin;
  assign short_pulse   = stopped & ~(|changed) & (pulse_cnt_reg != 8'h00);
  assign hold_last     = option_reg[`RC_OPT_XTAL_ENABLE] ?
                         CNT_W'(HOLD_XTAL_CYCLES - 1) :
                         CNT_W'(HOLD_CYCLES - 1);
  assign wr            = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];

  // Reset and recovery sequence.
  always_ff @(posedge clk_i) begin
    if (rst_i || sys_req) begin
      state_reg         <= reset_ctrl_pkg::st_osc_start;
      cnt_reg           <= '0;
      recovery_reg      <= 1'b0;
      watchdog_wake_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        reset_ctrl_pkg::st_osc_start: begin
          if (cnt_reg == CNT_W'(OSC_START_CYCLES - 1)) begin
            state_reg <= reset_ctrl_pkg::st_hold;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        reset_ctrl_pkg::st_hold: begin
          if (cnt_reg == hold_last) begin
            cnt_reg   <= '0;
            state_reg <= pin_asserted ? reset_ctrl_pkg::st_pin_wait
                                      : reset_ctrl_pkg::st_run;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        reset_ctrl_pkg::st_pin_wait: begin
          if (!pin_asserted) begin
            state_reg <= reset_ctrl_pkg::st_run;
          end
        end
        reset_ctrl_pkg::st_run: begin
          if (stop_enter_i) begin
            state_reg <= reset_ctrl_pkg::st_stop;
          end
        end
        reset_ctrl_pkg::st_stop: begin
          if (wake) begin
            state_reg         <= reset_ctrl_pkg::st_osc_start;
            cnt_reg           <= '0;
            recovery_reg      <= 1'b1;
            watchdog_wake_reg <= wake_watchdog;
          end
        end
      endcase
    end
  end

  // Pin reference level and pulse width while stopped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_ref_reg <= '0;
    end else if (running && stop_enter_i) begin
      level_ref_reg <= gpio_s;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !stopped || !(|changed)) begin
      pulse_cnt_reg <= 8'h00;
    end else begin
      pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
    end
  end

  // Outputs to the core and the pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_reset_reg      <= 1'b1;
      periph_reset_reg    <= 1'b1;
      vector_fetch_reg    <= 1'b0;
      watchdog_irq_reg    <= 1'b0;
      port_capture_en_reg <= 1'b0;
      stopped_reg         <= 1'b0;
      osc_run_reg         <= 1'b1;
    end else begin
      core_reset_reg      <= in_reset(state_reg);
      periph_reset_reg    <= in_reset(state_reg) & ~recovery_reg;
      vector_fetch_reg    <= running & core_reset_reg;
      watchdog_irq_reg    <= running & core_reset_reg & recovery_reg &
                             watchdog_wake_reg & irq_enable_i &
                             ~option_reg[`RC_OPT_WATCHDOG_RESET];
      port_capture_en_reg <= running;
      stopped_reg         <= stopped;
      osc_run_reg         <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_input_data_reg <= '0;
    end else if (running) begin
      port_input_data_reg <= gpio_s;
    end
  end

  // Software registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_reg <= `RC_OPTION_RESET;
    end else if (wr && hit(wb_adr_i, `RC_ADR_OPTION)) begin
      option_reg <= wb_dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_req) begin
      debugger_control_reg <= 1'b0;
    end else if (wr && hit(wb_adr_i, `RC_ADR_DEBUG_CTL)) begin
      debugger_control_reg <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_req) begin
      recovery_enable_reg <= '0;
    end else if (wr && hit(wb_adr_i, `RC_ADR_RECOVERY_EN)) begin
      recovery_enable_reg <= wb_dat_i[GPIO_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_req || wake) begin
      oscillator_control_reg <= `RC_CLKSEL_INTERNAL;
    end else if (wr && hit(wb_adr_i, `RC_ADR_OSCILLATOR_CONTROL_REG)) begin
      oscillator_control_reg <= wb_dat_i[1:0];
    end
  end

  // Flags clear on a written one; a flag event in the same cycle wins.
  logic [1:0] wctl_clr;
  logic [1:0] wctl_set;
  logic [5:0] stat_clr;
  logic [5:0] stat_set;

  always_comb begin
    wctl_clr = '0;
    stat_clr = '0;
    if (wr && hit(wb_adr_i, `RC_ADR_WATCHDOG_CTL)) begin
      wctl_clr = wb_dat_i[1:0];
    end
    if (wr && hit(wb_adr_i, `RC_ADR_RESET_STATUS)) begin
      stat_clr = wb_dat_i[5:0];
    end
    wctl_set = '0;
    wctl_set[`RC_WCTL_TIMEOUT] = wake_watchdog;
    wctl_set[`RC_WCTL_STOP]    = wake;
    stat_set = '0;
    stat_set[`RC_STAT_BROWNOUT] = brownout_s;
    stat_set[`RC_STAT_WATCHDOG] = watchdog_req;
    stat_set[`RC_STAT_PIN]      = pin_req;
    stat_set[`RC_STAT_DEBUGGER] = debugger_control_reg | debug_low_req;
    stat_set[`RC_STAT_STOP]     = short_pulse;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sys_req) begin
      watchdog_control_reg <= 2'h0;
    end else begin
      watchdog_control_reg <= (watchdog_control_reg & ~wctl_clr) | wctl_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_status_reg <= `RC_STAT_POWER_ON_VAL;
    end else if (sys_req) begin
      reset_status_reg <= stat_set;
    end else begin
      reset_status_reg <= (reset_status_reg & ~stat_clr) | stat_set;
    end
  end

  // Wishbone slave: one wait state, then a one-cycle acknowledge.
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    if (hit(wb_adr_i, `RC_ADR_DEBUG_CTL)) begin
      rbyte[0] = debugger_control_reg;
    end else if (hit(wb_adr_i, `RC_ADR_OPTION)) begin
      rbyte[2:0] = option_reg;
    end else if (hit(wb_adr_i, `RC_ADR_WATCHDOG_CTL)) begin
      rbyte[1:0] = watchdog_control_reg;
    end else if (hit(wb_adr_i, `RC_ADR_RESET_STATUS)) begin
      rbyte[5:0] = reset_status_reg;
    end else if (hit(wb_adr_i, `RC_ADR_OSCILLATOR_CONTROL_REG)) begin
      rbyte[1:0] = oscillator_control_reg;
    end else if (hit(wb_adr_i, `RC_ADR_RECOVERY_EN)) begin
      rbyte[GPIO_W-1:0] = recovery_enable_reg;
    end else if (hit(wb_adr_i, `RC_ADR_PORT_IN)) begin
      rbyte[GPIO_W-1:0] = port_input_data_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= wb_cyc_i & wb_stb_i & ~ack_reg;
      rdata_reg <= {24'h000000, rbyte};
    end
  end

  assign wb_ack_o            = ack_reg;
  assign wb_dat_o            = rdata_reg;
  assign core_reset_o        = core_reset_reg;
  assign periph_reset_o      = periph_reset_reg;
  assign gpio_force_input_o  = periph_reset_reg;
  assign vector_fetch_o      = vector_fetch_reg;
  assign vector_addr_lo_o    = `RC_VECTOR_ADDR_LO;
  assign vector_addr_hi_o    = `RC_VECTOR_ADDR_HI;
  assign watchdog_irq_o      = watchdog_irq_reg;
  assign xtal_osc_run_o      = option_reg[`RC_OPT_XTAL_ENABLE];
  assign watchdog_osc_run_o  = osc_run_reg;
  assign xtal_pin_override_o = option_reg[`RC_OPT_XTAL_ENABLE];
  assign sys_clk_sel_o       = oscillator_control_reg;
  assign port_input_data_o   = port_input_data_reg;
  assign port_capture_en_o   = port_capture_en_reg;
  assign stopped_o           = stopped_reg;

endmodule // reset_and_stop_recovery_ctrl

// *** verification/reset_ctrl_props.sv ***
// Concurrent checks on the reset controller's top-level ports.
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module reset_ctrl_props #(
  parameter int GPIO_W           = 8,
  parameter int HOLD_XTAL_CYCLES = `RC_HOLD_XTAL_CYCLES,
  parameter int MIN_PULSE_CYCLES = `RC_MIN_PULSE_CYCLES
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              core_reset_o,
  input wire logic              periph_reset_o,
  input wire logic              gpio_force_input_o,
  input wire logic              vector_fetch_o,
  input wire logic [15:0]       vector_addr_lo_o,
  input wire logic [15:0]       vector_addr_hi_o,
  input wire logic              watchdog_irq_o,
  input wire logic              watchdog_osc_run_o,
  input wire logic              xtal_osc_run_o,
  input wire logic              xtal_pin_override_o,
  input wire logic [1:0]        sys_clk_sel_o,
  input wire logic [GPIO_W-1:0] port_input_data_o,
  input wire logic              stopped_o
);
  logic [12:0] hold_n;

  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counts core reset cycles so the hold length can be judged at release.
  always_ff @(posedge clk_i) begin
    if (rst_i || !core_reset_o) begin
      hold_n <= 13'h0000;
    end else if (hold_n != 13'h1FFF) begin
      hold_n <= hold_n + 13'h0001;
    end
  end

  a_ack_one_wait: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow a request by one cycle");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_read_upper_zero: assert property (
    wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_vector_at_release: assert property (
    1'b1 |-> vector_fetch_o == $fell(core_reset_o))
    else $error("vector fetch not aligned with core release");
  a_vector_address: assert property (
    vector_addr_lo_o == 16'h0002 && vector_addr_hi_o == 16'h0003)
    else $error("reset vector address wrong");
  a_gpio_as_inputs: assert property (
    gpio_force_input_o == periph_reset_o)
    else $error("gpio not forced to input during reset");
  a_osc_keeps_running: assert property (
    core_reset_o |-> watchdog_osc_run_o)
    else $error("watchdog oscillator stopped during reset");
  a_clock_back_internal: assert property (
    periph_reset_o && $past(periph_reset_o) |->
      sys_clk_sel_o == `RC_CLKSEL_INTERNAL)
    else $error("system clock not internal during reset");
  a_xtal_pin_override: assert property (
    xtal_pin_override_o == xtal_osc_run_o)
    else $error("crystal pin override differs from crystal enable");
  a_hold_length: assert property (
    $fell(core_reset_o) |-> hold_n >= 13'h01D2)
    else $error("core released before start-up plus hold");
  a_irq_after_recovery: assert property (
    watchdog_irq_o |-> vector_fetch_o)
    else $error("watchdog interrupt not at end of recovery");
  a_port_frozen_stop: assert property (
    stopped_o && $past(stopped_o) |-> $stable(port_input_data_o))
    else $error("port input data changed while stopped");
endmodule // reset_ctrl_props

bind reset_and_stop_recovery_ctrl reset_ctrl_props #(
  .GPIO_W(GPIO_W), .HOLD_XTAL_CYCLES(HOLD_XTAL_CYCLES),
  .MIN_PULSE_CYCLES(MIN_PULSE_CYCLES)
) reset_ctrl_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .core_reset_o(core_reset_o), .periph_reset_o(periph_reset_o),
  .gpio_force_input_o(gpio_force_input_o),
  .vector_fetch_o(vector_fetch_o), .vector_addr_lo_o(vector_addr_lo_o),
  .vector_addr_hi_o(vector_addr_hi_o), .watchdog_irq_o(watchdog_irq_o),
  .watchdog_osc_run_o(watchdog_osc_run_o),
  .xtal_osc_run_o(xtal_osc_run_o),
  .xtal_pin_override_o(xtal_pin_override_o),
  .sys_clk_sel_o(sys_clk_sel_o), .port_input_data_o(port_input_data_o),
  .stopped_o(stopped_o)
);

// *** verification/far_side_model.sv ***
// Behavioural core and watchdog that face the controller.
`timescale 1ns/1ps
module far_side_model (
  input  wire logic clk_i,
  input  wire logic core_reset_i,
  input  wire logic vector_fetch_i,
  input  wire logic watchdog_irq_i,
  input  wire logic stop_req_i,
  input  wire logic wdt_req_i,
  output logic      stop_enter_o,
  output logic      watchdog_timeout_o,
  output int        irq_count_o
);
  logic wdt_q;

  initial irq_count_o = 0;
  // The core is idle in reset, so it only executes a stop while running.
  always_ff @(posedge clk_i) begin
    stop_enter_o <= stop_req_i && !core_reset_i;
  end
  // The watchdog runs on its own oscillator, in reset as well.
  always_ff @(posedge clk_i) begin
    wdt_q <= wdt_req_i;
    watchdog_timeout_o <= wdt_req_i && !wdt_q;
  end
  always @(posedge clk_i) begin
    if (watchdog_irq_i && vector_fetch_i) begin
      irq_count_o <= irq_count_o + 1;
    end
  end
endmodule // far_side_model

// *** verification/testbench.sv ***
// Register-level test sequence for the reset and recovery controller.
`timescale 1ns/1ps
`include "reset_ctrl_params.svh"
module testbench;
  localparam int OSC = `RC_OSC_START_NS * `RC_CLK_MHZ / 1000;
  localparam int HOLD = `RC_HOLD_CYCLES;
  localparam int XTAL = 100;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic brownout = 1'b0, pin_n = 1'b1, dbg = 1'b1, irq_en = 1'b0;
  logic stop_req = 1'b0, wdt_req = 1'b0;
  logic [7:0] gpio = 8'h00;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, core_rst, per_rst, vfetch, wirq, stopped, stop_en, wdt_to;
  logic [7:0] port_data;
  logic xovr;
  int n, irq_count, n_errors = 0, checks = 0;

  reset_and_stop_recovery_ctrl #(.HOLD_XTAL_CYCLES(XTAL))
    reset_and_stop_recovery_ctrl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .supply_brownout_i(brownout), .reset_pin_n_i(pin_n),
    .debug_pin_i(dbg), .gpio_i(gpio), .watchdog_timeout_i(wdt_to),
    .stop_enter_i(stop_en), .irq_enable_i(irq_en),
    .core_reset_o(core_rst), .periph_reset_o(per_rst),
    .gpio_force_input_o(), .vector_fetch_o(vfetch),
    .vector_addr_lo_o(), .vector_addr_hi_o(), .watchdog_irq_o(wirq),
    .xtal_osc_run_o(), .watchdog_osc_run_o(), .xtal_pin_override_o(xovr),
    .sys_clk_sel_o(), .port_input_data_o(port_data),
    .port_capture_en_o(), .stopped_o(stopped));

  far_side_model far_side_model_i (
    .clk_i(clk_i), .core_reset_i(core_rst), .vector_fetch_i(vfetch),
    .watchdog_irq_i(wirq), .stop_req_i(stop_req), .wdt_req_i(wdt_req),
    .stop_enter_o(stop_en), .watchdog_timeout_o(wdt_to),
    .irq_count_o(irq_count));

  always #5 clk_i = ~clk_i;

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= {24'h000000, d};
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (k >= 20) chk("bus ack", 32'h0, 32'h1);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    wb(a, 1'b0, 8'h00);
    chk("read data", q & {24'h000000, m}, {24'h000000, e});
  endtask

  task wait_core(input logic v, input int lim);
    n = 0;
    while (core_rst !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk("core reset", 32'(core_rst), 32'(v));
  endtask

  task in_range(input int lo, input int hi);
    chk("reset length", 32'(n >= lo && n <= hi), 32'h1);
  endtask

  task stop_dev;
    stop_req <= 1'b1;
    n = 0;
    while (stopped !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    stop_req <= 1'b0;
    chk("stopped", 32'(stopped), 32'h1);
  endtask

  task fire_wdt;
    @(posedge clk_i);
    wdt_req <= 1'b1;
    @(posedge clk_i);
    wdt_req <= 1'b0;
  endtask

  task report_and_stop;
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #(800000);
    n_errors++;
    report_and_stop;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_core(1'b0, 2000);
    in_range(OSC + HOLD - 2, OSC + HOLD + 8);
    rd(`RC_ADR_RESET_STATUS, 8'hFF, 8'h01);
    rd(`RC_ADR_OPTION, 8'hFF, 8'h04);
    rd(`RC_ADR_WATCHDOG_CTL, 8'hFF, 8'h00);
    rd(8'h1C, 8'hFF, 8'h00);
    wb(`RC_ADR_OSCILLATOR_CONTROL_REG, 1'b1, 8'h02);
    rd(`RC_ADR_OSCILLATOR_CONTROL_REG, 8'hFF, 8'h02);
    wb(`RC_ADR_DEBUG_CTL, 1'b1, 8'h01);
    wait_core(1'b1, 30);
    chk("periph reset", 32'(per_rst), 32'h1);
    wait_core(1'b0, 2000);
    rd(`RC_ADR_OSCILLATOR_CONTROL_REG, 8'hFF, 8'h00);
    rd(`RC_ADR_RESET_STATUS, 8'h10, 8'h10);
    wb(`RC_ADR_OPTION, 1'b1, 8'h06);
    wb(`RC_ADR_DEBUG_CTL, 1'b1, 8'h01);
    chk("xtal override", 32'(xovr), 32'h1);
    wait_core(1'b1, 30);
    wait_core(1'b0, 2000);
    in_range(OSC + XTAL - 2, OSC + XTAL + 8);
    wb(`RC_ADR_OPTION, 1'b1, 8'h04);
    pin_n <= 1'b0;
    wait_core(1'b1, 30);
    repeat (700) @(posedge clk_i);
    chk("pin held reset", 32'(core_rst), 32'h1);
    pin_n <= 1'b1;
    wait_core(1'b0, 30);
    in_range(1, 20);
    rd(`RC_ADR_RESET_STATUS, 8'h08, 8'h08);
    brownout <= 1'b1;
    wait_core(1'b1, 30);
    repeat (30) @(posedge clk_i);
    brownout <= 1'b0;
    wait_core(1'b0, 2000);
    in_range(OSC + HOLD, OSC + HOLD + 10);
    rd(`RC_ADR_RESET_STATUS, 8'h02, 8'h02);
    wb(`RC_ADR_OPTION, 1'b1, 8'h05);
    fire_wdt;
    wait_core(1'b1, 30);
    chk("periph reset", 32'(per_rst), 32'h1);
    wait_core(1'b0, 2000);
    rd(`RC_ADR_RESET_STATUS, 8'h04, 8'h04);
    wb(`RC_ADR_OPTION, 1'b1, 8'h04);
    wb(`RC_ADR_OSCILLATOR_CONTROL_REG, 1'b1, 8'h01);
    wb(`RC_ADR_WATCHDOG_CTL, 1'b1, 8'h03);
    irq_en <= 1'b1;
    stop_dev;
    fire_wdt;
    wait_core(1'b1, 30);
    chk("periph in recovery", 32'(per_rst), 32'h0);
    wait_core(1'b0, 2000);
    rd(`RC_ADR_WATCHDOG_CTL, 8'hFF, 8'h03);
    rd(`RC_ADR_OSCILLATOR_CONTROL_REG, 8'hFF, 8'h00);
    chk("watchdog irq", 32'(irq_count), 32'h1);
    wb(`RC_ADR_WATCHDOG_CTL, 1'b1, 8'h03);
    wb(`RC_ADR_RECOVERY_EN, 1'b1, 8'h01);
    stop_dev;
    gpio <= 8'h01;
    wait_core(1'b1, 40);
    chk("periph in recovery", 32'(per_rst), 32'h0);
    wait_core(1'b0, 2000);
    rd(`RC_ADR_WATCHDOG_CTL, 8'hFF, 8'h02);
    rd(`RC_ADR_PORT_IN, 8'hFF, 8'h01);
    chk("port data", 32'(port_data), 32'h1);
    wb(`RC_ADR_RESET_STATUS, 1'b1, 8'hFF);
    stop_dev;
    @(posedge clk_i);
    gpio <= 8'h00;
    repeat (2) @(posedge clk_i);
    gpio <= 8'h01;
    repeat (20) @(posedge clk_i);
    chk("short pulse", 32'({stopped, core_rst}), 32'h2);
    rd(`RC_ADR_RESET_STATUS, 8'hFF, 8'h20);
    dbg <= 1'b0;
    wait_core(1'b1, 30);
    chk("debug low reset", 32'(per_rst), 32'h1);
    dbg <= 1'b1;
    wait_core(1'b0, 2000);
    rd(`RC_ADR_RESET_STATUS, 8'h10, 8'h10);
    report_and_stop;
  end
endmodule // testbench
